// file: hdl/mpf_map.svh
// register offsets, field positions, reset values and timing counts
// for the pause flow-control block; included by the package users.
`ifndef MPF_MAP_SVH
`define MPF_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MPF_MGMT_CTRL_OFS  12'h414
`define MPF_PHY_DATA_OFS   12'h418
`define MPF_PAUSE_CTRL_OFS 12'h41C
`define MPF_IRQ_STS_OFS    12'h440
`define MPF_IRQ_MSK_OFS    12'h444
`define MPF_MAC_CFG_OFS    12'h448
// ----------------------------------------------------------------
// field positions and reset value
// ----------------------------------------------------------------
`define MPF_PAUSE_DURATION_LSB      16
`define MPF_PCF_BIT        2
`define MPF_FCE_BIT        1
`define MPF_FCB_BIT        0
`define MPF_PADDR_LSB      11
`define MPF_RIDX_LSB       6
`define MPF_PRE_BIT        2
`define MPF_DIR_BIT        1
`define MPF_BUSY_BIT       0
`define MPF_DUPLEX_BIT     0
`define MPF_IRQ_MGMT       0
`define MPF_IRQ_PTX        1
`define MPF_IRQ_PRX        2
`define MPF_IRQ_CRX        3
`define MPF_REG_RESET      32'h0000_0000
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MPF_CLK_NS         20
`define MPF_QUANTUM_NS     5120
`define MPF_QUANTUM_CYC    (`MPF_QUANTUM_NS / `MPF_CLK_NS)
`define MPF_MDC_HALF_CYC   10
`endif

// file: hdl/mpf_pkg.sv
// types shared by the pause flow-control block
// assumes mpf_map.svh sits beside it
package mpf_pkg;
  typedef enum logic [1:0] {
    MPF_MD_IDLE  = 2'b00,
    MPF_MD_START = 2'b01,
    MPF_MD_SHIFT = 2'b10
  } mpf_mdio_st_t;

  // whole state of the block
  typedef struct packed {
    mpf_mdio_st_t st;
    logic [6:0]   idx;
    logic [7:0]   div;
    logic         mdc;
    logic         mdo;
    logic         mdoe;
    logic         s1;
    logic         s2;
    logic [4:0]   phy_addr;
    logic [4:0]   phy_reg_index;
    logic         pre_skip;
    logic         dir;
    logic [15:0]  phy_data_holding;
    logic [15:0]  shin;
    logic [15:0]  pause_duration;
    logic         pass_control_frames;
    logic         flow_ctrl_enable;
    logic         pause_tx_busy;
    logic         full_duplex;
    logic [15:0]  pause_left;
    logic [8:0]   qtimer;
    logic         tx_hold;
    logic         cf;
    logic         pf;
    logic         rx_stb;
    logic [3:0]   sts;
    logic [3:0]   msk;
    logic         irq;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } mpf_state_t;
endpackage : mpf_pkg

// file: hdl/mpf_flow_ctrl.sv
// pause flow control, PHY management data and MDIO engine of the MAC
// assumes an APB master on clk and a MAC tx/rx path on the same clock;
// mdio_i arrives from a pin and is synchronised here.
//
// Behaviour
// - data holding low half: PHY read/write data
// - data holding upper half reads zero
// - pause duration goes into sent PAUSE frames
// - pass clear: flag control, clear pass flag
// - pass set: both flags set, frame delivered
// - enabled pause halts new frames, current finishes
// - disabled: no halt, control flag still set
// - pause acts only in full duplex
// - software sets busy, MAC clears when sent
// - management busy set starts, cleared on completion
// - direction zero reads, one writes
//
// Implementation choice: the APB interface to the registers.
`include "mpf_map.svh"

module mpf_flow_ctrl (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mdc,
  output logic             mdio_o,
  output logic             mdio_oe,
  input  wire logic        mdio_i,
  output logic             pause_tx_req,
  output logic      [15:0] pause_tx_quanta,
  input  wire logic        pause_tx_done,
  input  wire logic        tx_in_frame,
  output logic             tx_hold,
  input  wire logic        rx_ctrl_valid,
  input  wire logic        rx_ctrl_is_pause,
  input  wire logic [15:0] rx_pause_quanta,
  output logic             control_frame_flag,
  output logic             pass_frame_flag,
  output logic             rx_status_strobe,
  output logic             irq
);
  import mpf_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_MGMT  = 3'h1;
  localparam logic [2:0] SEL_DATA  = 3'h2;
  localparam logic [2:0] SEL_PAUSE = 3'h3;
  localparam logic [2:0] SEL_STS   = 3'h4;
  localparam logic [2:0] SEL_MSK   = 3'h5;
  localparam logic [2:0] SEL_CFG   = 3'h6;

  // maps a byte address to a register select, none if unmapped
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    case (a)
      `MPF_MGMT_CTRL_OFS:  reg_sel = SEL_MGMT;
      `MPF_PHY_DATA_OFS:   reg_sel = SEL_DATA;
      `MPF_PAUSE_CTRL_OFS: reg_sel = SEL_PAUSE;
      `MPF_IRQ_STS_OFS:    reg_sel = SEL_STS;
      `MPF_IRQ_MSK_OFS:    reg_sel = SEL_MSK;
      `MPF_MAC_CFG_OFS:    reg_sel = SEL_CFG;
      default:             reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  localparam logic [8:0] QUANTUM_LAST = 9'(`MPF_QUANTUM_CYC - 1);
  localparam logic [7:0] MDC_LAST     = 8'(`MPF_MDC_HALF_CYC - 1);

  mpf_state_t r_reg;
  mpf_state_t r_next;

  logic [2:0]  wsel;
  logic [2:0]  rsel;
  logic        wr_en;
  logic [63:0] frm;
  logic [31:0] rd_word;

  assign wsel  = reg_sel(paddr);
  assign rsel  = wsel;
  assign wr_en = psel && penable && pwrite && r_reg.pready;

  // management frame: preamble, start, op, addresses, turnaround, data
  assign frm = {32'hFFFF_FFFF, 2'b01,
                r_reg.dir ? 2'b01 : 2'b10,
                r_reg.phy_addr, r_reg.phy_reg_index,
                r_reg.dir ? 2'b10 : 2'b00,
                r_reg.phy_data_holding};

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = `MPF_REG_RESET;
    case (rsel)
      SEL_MGMT: begin
        rd_word[`MPF_PADDR_LSB +: 5] = r_reg.phy_addr;
        rd_word[`MPF_RIDX_LSB +: 5]  = r_reg.phy_reg_index;
        rd_word[`MPF_PRE_BIT]        = r_reg.pre_skip;
        rd_word[`MPF_DIR_BIT]        = r_reg.dir;
        rd_word[`MPF_BUSY_BIT]       = r_reg.st != MPF_MD_IDLE;
      end
      SEL_DATA: begin
        rd_word[15:0] = r_reg.phy_data_holding; // upper half zero
      end
      SEL_PAUSE: begin
        rd_word[`MPF_PAUSE_DURATION_LSB +: 16] = r_reg.pause_duration;
        rd_word[`MPF_PCF_BIT] = r_reg.pass_control_frames;
        rd_word[`MPF_FCE_BIT] = r_reg.flow_ctrl_enable;
        rd_word[`MPF_FCB_BIT] = r_reg.pause_tx_busy;
      end
      SEL_STS:  rd_word[3:0] = r_reg.sts;
      SEL_MSK:  rd_word[3:0] = r_reg.msk;
      SEL_CFG:  rd_word[`MPF_DUPLEX_BIT] = r_reg.full_duplex;
      default:  rd_word = `MPF_REG_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] ev;
    logic [3:0] w1c;
    ev     = 4'h0;
    w1c    = 4'h0;
    r_next = r_reg;

    // pin synchroniser, only s2 is read
    r_next.s1 = mdio_i;
    r_next.s2 = r_reg.s1;

    // apb answer: one wait state, then pready for one cycle
    r_next.pready  = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h0000_0000;
    if (psel && penable && !r_reg.pready) begin
      r_next.pready  = 1'b1;
      r_next.pslverr = wsel == SEL_NONE;
      r_next.prdata  = pwrite ? 32'h0000_0000 : rd_word;
    end

    // register writes take effect on the pready edge
    if (wr_en) begin
      case (wsel)
        SEL_MGMT: begin
          if (r_reg.st == MPF_MD_IDLE) begin // fields held while busy
            r_next.phy_addr      = pwdata[`MPF_PADDR_LSB +: 5];
            r_next.phy_reg_index = pwdata[`MPF_RIDX_LSB +: 5];
            r_next.pre_skip      = pwdata[`MPF_PRE_BIT];
            r_next.dir           = pwdata[`MPF_DIR_BIT];
            if (pwdata[`MPF_BUSY_BIT]) begin
              r_next.st = MPF_MD_START;
            end
          end
        end
        SEL_DATA: begin
          r_next.phy_data_holding = pwdata[15:0];
        end
        SEL_PAUSE: begin
          r_next.pause_duration      = pwdata[`MPF_PAUSE_DURATION_LSB +: 16];
          r_next.pass_control_frames = pwdata[`MPF_PCF_BIT];
          r_next.flow_ctrl_enable    = pwdata[`MPF_FCE_BIT];
        end
        SEL_STS:  w1c = pwdata[3:0];
        SEL_MSK:  r_next.msk = pwdata[3:0];
        SEL_CFG:  r_next.full_duplex = pwdata[`MPF_DUPLEX_BIT];
        default:  ;
      endcase
    end

    // mdio engine: drive on mdc fall, sample on mdc rise
    case (r_reg.st)
      MPF_MD_IDLE: begin
        r_next.mdc  = 1'b0;
        r_next.mdoe = 1'b0;
      end
      MPF_MD_START: begin
        r_next.idx  = r_reg.pre_skip ? 7'd32 : 7'd0;
        r_next.div  = 8'h00;
        r_next.mdc  = 1'b0;
        r_next.mdoe = 1'b1;
        r_next.mdo  = frm[~r_next.idx[5:0]];
        r_next.st   = MPF_MD_SHIFT;
      end
      MPF_MD_SHIFT: begin
        if (r_reg.div == MDC_LAST) begin
          r_next.div = 8'h00;
          r_next.mdc = ~r_reg.mdc;
          if (!r_reg.mdc) begin
            // rising edge: read data bits are sampled
            if (!r_reg.dir && r_reg.idx >= 7'd48) begin
              r_next.shin = {r_reg.shin[14:0], r_reg.s2};
            end
            r_next.idx = r_reg.idx + 7'd1;
          end else if (r_reg.idx == 7'd64) begin
            // falling edge after the last bit ends the access
            r_next.st   = MPF_MD_IDLE;
            r_next.mdoe = 1'b0;
            r_next.mdc  = 1'b0;
            ev[`MPF_IRQ_MGMT] = 1'b1;
            if (!r_reg.dir) begin
              r_next.phy_data_holding = r_reg.shin;
            end
          end else begin
            r_next.mdo  = frm[~r_reg.idx[5:0]];
            r_next.mdoe = r_reg.dir || r_reg.idx < 7'd46;
          end
        end else begin
          r_next.div = r_reg.div + 8'h01;
        end
      end
      default: begin
        r_next.st   = MPF_MD_IDLE;
        r_next.mdoe = 1'b0;
      end
    endcase

    // pause transmit request: software set wins over completion
    if (r_reg.pause_tx_busy && pause_tx_done) begin
      r_next.pause_tx_busy = 1'b0;
      ev[`MPF_IRQ_PTX]     = 1'b1;
    end
    if (wr_en && wsel == SEL_PAUSE && pwdata[`MPF_FCB_BIT]) begin
      r_next.pause_tx_busy = 1'b1;
    end

    // pause countdown in quanta, frozen while a frame is on the wire
    if (!r_reg.full_duplex) begin
      r_next.pause_left = 16'h0000;
      r_next.qtimer     = 9'h000;
    end else if (r_reg.pause_left != 16'h0000 && !tx_in_frame) begin
      if (r_reg.qtimer == QUANTUM_LAST) begin
        r_next.qtimer     = 9'h000;
        r_next.pause_left = r_reg.pause_left - 16'h0001;
      end else begin
        r_next.qtimer = r_reg.qtimer + 9'h001;
      end
    end

    // received control frame decode
    r_next.rx_stb = 1'b0;
    if (rx_ctrl_valid) begin
      r_next.rx_stb = 1'b1;
      r_next.cf     = 1'b1;
      r_next.pf     = r_reg.pass_control_frames;
      ev[`MPF_IRQ_CRX] = 1'b1;
      if (rx_ctrl_is_pause && r_reg.flow_ctrl_enable &&
          r_reg.full_duplex) begin
        r_next.pause_left = rx_pause_quanta;
        r_next.qtimer     = 9'h000;
        ev[`MPF_IRQ_PRX]  = 1'b1;
      end
    end
    r_next.tx_hold = r_next.pause_left != 16'h0000;

    // sticky status, set wins over write-one-to-clear
    r_next.sts = (r_reg.sts & ~w1c) | ev;
    r_next.irq = |(r_next.sts & r_next.msk);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign prdata             = r_reg.prdata;
  assign pready             = r_reg.pready;
  assign pslverr            = r_reg.pslverr;
  assign mdc                = r_reg.mdc;
  assign mdio_o             = r_reg.mdo;
  assign mdio_oe            = r_reg.mdoe;
  assign pause_tx_req       = r_reg.pause_tx_busy;
  assign pause_tx_quanta    = r_reg.pause_duration;
  assign tx_hold            = r_reg.tx_hold;
  assign control_frame_flag = r_reg.cf;
  assign pass_frame_flag    = r_reg.pf;
  assign rx_status_strobe   = r_reg.rx_stb;
  assign irq                = r_reg.irq;
endmodule : mpf_flow_ctrl

// file: dv/mpf_chk.sv
// checker: port-level assertions for the pause flow-control block
// assumes one clk domain and sync active-high sys_rst
`include "mpf_map.svh"
module mpf_chk (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pause_tx_req,
  input wire logic        pause_tx_done,
  input wire logic        tx_in_frame,
  input wire logic        tx_hold,
  input wire logic        rx_ctrl_valid,
  input wire logic        rx_ctrl_is_pause,
  input wire logic        control_frame_flag,
  input wire logic        rx_status_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // register access, pause transmit, pause receive
  // ------------------------------------------------------------
  a_ready_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("pready late");
  a_data_upper: assert property (pready && !pwrite &&
    paddr == `MPF_PHY_DATA_OFS |-> prdata[31:16] == 16'h0000)
    else $error("data upper half not zero");
  a_busy_clear: assert property (pause_tx_done && pause_tx_req &&
    !(psel && pwrite) |=> !pause_tx_req)
    else $error("pause busy not cleared");
  a_rx_status: assert property (rx_ctrl_valid |=>
    rx_status_strobe && control_frame_flag)
    else $error("control frame not flagged");
  a_flag_sticky: assert property (control_frame_flag |=>
    control_frame_flag) else $error("control flag dropped");
  a_hold_cause: assert property ($rose(tx_hold) |->
    $past(rx_ctrl_valid && rx_ctrl_is_pause))
    else $error("hold without pause frame");
  a_hold_frozen: assert property (tx_hold && tx_in_frame && !psel &&
    !rx_ctrl_valid |=> tx_hold) else $error("hold ran out in frame");
  a_hold_min: assert property ($rose(tx_hold) |=> tx_hold[*8])
    else $error("hold too short");
  c_hold: cover property ($rose(tx_hold));
  c_ptx: cover property (pause_tx_done);
  c_rx: cover property (rx_status_strobe);
endmodule : mpf_chk
bind mpf_flow_ctrl mpf_chk u_chk (.clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pause_tx_req, .pause_tx_done,
  .tx_in_frame, .tx_hold, .rx_ctrl_valid, .rx_ctrl_is_pause,
  .control_frame_flag, .rx_status_strobe);

// file: dv/mpf_link_model.sv
// far side: PHY on MDIO (pull-up line) and tx path answering PAUSE
// assumes preamble-skip frames, 32 bits, data slots 16..31
module mpf_link_model #(
  parameter logic [15:0] RD = 16'hC3A5
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  input  wire logic pause_tx_req,
  output logic      mdio_i,
  output logic      pause_tx_done,
  output logic [15:0] wr_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] bc;
  logic       mdc_q;
  logic       oe_q;
  logic [2:0] dly;
  // count mdc rises per frame; tx path sends PAUSE after a delay
  always_ff @(posedge clk) begin
    mdc_q <= mdc;
    oe_q  <= mdio_oe;
    if (sys_rst || (mdio_oe && !oe_q)) bc <= '0;
    else if (mdc && !mdc_q) bc <= bc + 6'd1;
    // phy side captures written data bits at mdc rises, msb first
    if (sys_rst) wr_seen <= '0;
    else if (mdc && !mdc_q && bc >= 16 && bc < 32)
      wr_seen <= {wr_seen[14:0], mdio_o};
    if (sys_rst || !pause_tx_req) dly <= '0;
    else if (dly != 3'd7) dly <= dly + 3'd1;
    pause_tx_done <= (dly == 3'd4);
  end
  // wire level: design, else PHY read data MSB first, else pull-up
  assign mdio_i = mdio_oe ? mdio_o :
    ((bc >= 16 && bc < 32) ? RD[31 - bc] : 1'b1);
endmodule : mpf_link_model

// file: dv/tb.sv
// testbench for the pause flow-control block over APB
// assumes mpf_map.svh on the include path and the link model
`include "mpf_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, psel, penable, pwrite, mdio_i, pause_tx_done;
  logic tx_in_frame, rx_ctrl_valid, rx_ctrl_is_pause;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] rx_pause_quanta, pause_tx_quanta, wr_seen;
  logic pready, pslverr, mdc, mdio_o, mdio_oe, pause_tx_req, tx_hold;
  logic control_frame_flag, pass_frame_flag, rx_status_strobe, irq, err;
  int mismatches, n_checks;
  mpf_flow_ctrl dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mdc, .mdio_o, .mdio_oe,
    .mdio_i, .pause_tx_req, .pause_tx_quanta, .pause_tx_done,
    .tx_in_frame, .tx_hold, .rx_ctrl_valid, .rx_ctrl_is_pause,
    .rx_pause_quanta, .control_frame_flag, .pass_frame_flag,
    .rx_status_strobe, .irq);
  mpf_link_model u_link (.clk, .sys_rst, .mdc, .mdio_o, .mdio_oe,
    .pause_tx_req, .mdio_i, .pause_tx_done, .wr_seen);
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      end_sim();
    end
  endtask : apb
  // poll a register until bit 0 reads clear, bounded
  task automatic poll(input logic [11:0] a);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 400);
    chk(q[0], 1'b0);
  endtask : poll
  task automatic rx(input logic p, input logic [15:0] qu);
    @(posedge clk);
    rx_ctrl_valid    <= 1'b1;
    rx_ctrl_is_pause <= p;
    rx_pause_quanta  <= qu;
    @(posedge clk);
    rx_ctrl_valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask : rx
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, `MPF_PAUSE_CTRL_OFS, 32'h0);
    chk(q, `MPF_REG_RESET);
    apb(1'b1, `MPF_PHY_DATA_OFS, 32'hFFFF_1234);
    apb(1'b0, `MPF_PHY_DATA_OFS, 32'h0);
    chk(q, 32'h0000_1234);
    apb(1'b0, 12'h000, 32'h0);
    chk(err, 1'b1);
    $display("done regs");
  endtask : t_regs
  // phy 1, register 2, no preamble, read; fields loaded while idle
  task automatic t_mdio;
    apb(1'b1, `MPF_MGMT_CTRL_OFS, 32'h0000_0885);
    poll(`MPF_MGMT_CTRL_OFS);
    apb(1'b0, `MPF_PHY_DATA_OFS, 32'h0);
    chk(q, 32'h0000_C3A5);
    // write access: data register value must appear on the wire
    apb(1'b1, `MPF_PHY_DATA_OFS, 32'h0000_5A5A);
    apb(1'b1, `MPF_MGMT_CTRL_OFS, 32'h0000_0887);
    poll(`MPF_MGMT_CTRL_OFS);
    chk(wr_seen, 16'h5A5A);
    apb(1'b0, `MPF_IRQ_STS_OFS, 32'h0);
    chk(q[0], 1'b1);
    $display("done mdio");
  endtask : t_mdio
  task automatic t_ptx;
    apb(1'b1, `MPF_IRQ_MSK_OFS, 32'h0000_0002);
    apb(1'b1, `MPF_PAUSE_CTRL_OFS, 32'hABCD_0001);
    repeat (2) @(posedge clk);
    chk(pause_tx_quanta, 16'hABCD);
    chk(pause_tx_req, 1'b1);
    poll(`MPF_PAUSE_CTRL_OFS);
    chk(irq, 1'b1);
    apb(1'b1, `MPF_IRQ_STS_OFS, 32'h0000_0002);
    @(posedge clk);
    #1;
    chk(irq, 1'b0);
    $display("done pause tx");
  endtask : t_ptx
  task automatic t_prx;
    apb(1'b1, `MPF_MAC_CFG_OFS, 32'h0000_0001);
    apb(1'b1, `MPF_PAUSE_CTRL_OFS, 32'h0000_0002);
    tx_in_frame <= 1'b1;
    rx(1'b1, 16'h0001);
    chk({control_frame_flag, pass_frame_flag}, 2'b10);
    chk(tx_hold, 1'b1);
    repeat (300) @(posedge clk);
    chk(tx_hold, 1'b1);
    tx_in_frame <= 1'b0;
    repeat (250) @(posedge clk);
    chk(tx_hold, 1'b1);
    repeat (20) @(posedge clk);
    chk(tx_hold, 1'b0);
    $display("done pause rx");
  endtask : t_prx
  task automatic t_pass;
    apb(1'b1, `MPF_PAUSE_CTRL_OFS, 32'h0000_0004);
    rx(1'b1, 16'h0001);
    chk({control_frame_flag, pass_frame_flag}, 2'b11);
    chk(tx_hold, 1'b0);
    apb(1'b1, `MPF_PAUSE_CTRL_OFS, 32'h0000_0002);
    apb(1'b1, `MPF_MAC_CFG_OFS, 32'h0000_0000);
    rx(1'b1, 16'h0001);
    chk(tx_hold, 1'b0);
    $display("done pass");
  endtask : t_pass
  // clock, reset for two cycles, then the sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {sys_rst, psel, penable, pwrite, tx_in_frame} = 5'b10000;
    {rx_ctrl_valid, rx_ctrl_is_pause} = 2'b00;
    {paddr, pwdata, rx_pause_quanta} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_mdio();
    t_ptx();
    t_prx();
    t_pass();
    end_sim();
  end
endmodule : tb
